/* File: serdes_channel_diag_eye_monitor.sv */
`timescale 1ns/1ps
`include "serdes_diag_cfg.svh"

// Operation
// - transmit repeating 16-bit user pattern or prbs, chosen by configuration
// - with dc balance on, every second user symbol goes out inverted
// - prbs lengths 2^7, 2^9, 2^15 and 2^31, each minus one
// - checker uses manual sequence and polarity, or detects both automatically
// - 47-bit compared word counter and 11-bit error counter
// - received data compared in 32-bit words, counter counts those words
// - host freezes checker before reading counters
// - horizontal opening in horizontal_opening_result, value over 64 gives unit intervals
// - vertical opening in vertical_opening_result, each count 3.125 mV
// - results follow lock; eye capture only runs while recovery is locked
// - capture covers 64 by 64 positions, 16-bit hit word each
// - vertical scale automatic unless overridden; horizontal follows data rate
// - readout gives 4 dummy words then 4096 valid words
// - first word (0,0); voltage advances, wraps after 63 and bumps phase
// - manual range: clear eye_scaling_ctrl[6], eye_range_power_ctrl[7:6] picks 100 to 400 mV
// - stream words from eye_word_high_byte in bursts, or high eye_word_high_byte and low eye_word_low_byte
// - capture start bit eye_readout_ctrl[0] clears itself
module serdes_channel_diag_eye_monitor (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_burst,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic      [15:0] tx_data,
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_valid,
    input  wire logic        cdr_locked,
    input  wire logic [3:0]  data_rate_code,
    input  wire logic [7:0]  horiz_meas,
    input  wire logic [7:0]  vert_meas,
    input  wire logic [15:0] eye_hits,
    output logic      [5:0]  eye_phase,
    output logic      [5:0]  eye_volt,
    output logic      [1:0]  eye_vrange,
    output logic      [3:0]  eye_hscale,
    output logic             eye_power_on,
    output logic             eye_fast
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic prbs_fb(input logic [30:0] h,
                                     input logic [1:0]  t);
        case (t)
            2'b00:   prbs_fb = h[6] ^ h[5];
            2'b01:   prbs_fb = h[8] ^ h[4];
            2'b10:   prbs_fb = h[14] ^ h[13];
            default: prbs_fb = h[30] ^ h[27];
        endcase
    endfunction

    function automatic logic [1:0] auto_range(input logic [7:0] v);
        if (v <= 8'h40) begin
            auto_range = 2'b00;
        end else if (v <= 8'h80) begin
            auto_range = 2'b01;
        end else if (v <= 8'hc0) begin
            auto_range = 2'b10;
        end else begin
            auto_range = 2'b11;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]  range_power_reg;
    logic [7:0]  scaling_reg;
    logic [7:0]  lock_mon_reg;
    logic        fast_reg;
    logic        aux_reg;
    logic [7:0]  gen_ctrl_reg;
    logic [15:0] pattern_reg;
    logic [7:0]  chk_ctrl_reg;
    logic [7:0]  horiz_reg;
    logic [7:0]  vert_reg;
    logic [2:0]  lock_sync_reg;
    logic        locked_reg;
    logic        start_req;

    assign start_req = reg_wr && reg_addr == `READOUT_CTRL_OFS
                       && reg_wdata[`START_BIT];

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            range_power_reg <= `RANGE_POWER_RST;
            scaling_reg     <= `SCALING_RST;
            lock_mon_reg    <= `LOCK_MON_RST;
            fast_reg        <= 1'b0;
            aux_reg         <= 1'b0;
            gen_ctrl_reg    <= 8'h00;
            pattern_reg     <= 16'h0000;
            chk_ctrl_reg    <= 8'h00;
        end else begin
            chk_ctrl_reg[6] <= 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    `RANGE_POWER_OFS:  range_power_reg <= reg_wdata;
                    `SCALING_CTRL_OFS: scaling_reg     <= reg_wdata;
                    `LOCK_MON_OFS:     lock_mon_reg    <= reg_wdata;
                    `READOUT_CTRL_OFS: begin
                        fast_reg <= reg_wdata[`FAST_BIT];
                        aux_reg  <= reg_wdata[`AUX_BIT];
                    end
                    `GEN_CTRL_OFS:     gen_ctrl_reg       <= reg_wdata;
                    `GEN_PAT_HI_OFS:   pattern_reg[15:8]  <= reg_wdata;
                    `GEN_PAT_LO_OFS:   pattern_reg[7:0]   <= reg_wdata;
                    `CHK_CTRL_OFS:     chk_ctrl_reg       <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // lock pin: three stages, change taken once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lock_sync_reg <= 3'b000;
            locked_reg    <= 1'b0;
        end else begin
            lock_sync_reg <= {lock_sync_reg[1:0], cdr_locked};
            if (lock_sync_reg[1] == lock_sync_reg[2]) begin
                locked_reg <= lock_sync_reg[2];
            end
        end
    end

    // opening results track the front end only while locked
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            horiz_reg <= 8'h00;
            vert_reg  <= 8'h00;
        end else if (locked_reg) begin
            horiz_reg <= horiz_meas;
            vert_reg  <= vert_meas;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scaling

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            eye_vrange   <= 2'b00;
            eye_hscale   <= 4'h0;
            eye_power_on <= 1'b0;
            eye_fast     <= 1'b0;
        end else begin
            eye_vrange <= scaling_reg[`AUTO_SCALE_BIT] ? auto_range(vert_reg)
                : range_power_reg[`RANGE_LSB +: 2];
            eye_hscale   <= data_rate_code;
            eye_power_on <= !range_power_reg[`POWER_DOWN_BIT];
            eye_fast     <= fast_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pattern generator

    logic [30:0] gen_hist_reg;
    logic        gen_odd_reg;
    logic [15:0] gen_word;
    logic [30:0] gen_hist_next;

    always_comb begin
        gen_hist_next = gen_hist_reg;
        gen_word      = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            gen_word[i]   = prbs_fb(gen_hist_next, gen_ctrl_reg[3:2]);
            gen_hist_next = {gen_hist_next[29:0], gen_word[i]};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tx_data      <= 16'h0000;
            gen_hist_reg <= `PRBS_SEED;
            gen_odd_reg  <= 1'b0;
        end else if (!gen_ctrl_reg[0]) begin
            tx_data     <= 16'h0000;
            gen_odd_reg <= 1'b0;
        end else if (gen_ctrl_reg[1]) begin
            tx_data      <= gen_word;
            gen_hist_reg <= gen_hist_next;
        end else begin
            gen_odd_reg <= gen_ctrl_reg[4] && !gen_odd_reg;
            tx_data <= (gen_ctrl_reg[4] && gen_odd_reg) ? ~pattern_reg
                                                        : pattern_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pattern checker

    logic [30:0] chk_hist_reg;
    logic [1:0]  chk_type_reg;
    logic        chk_inv_reg;
    logic        chk_sync_reg;
    logic [3:0]  chk_good_reg;
    logic [46:0] word_cnt_reg;
    logic [10:0] err_cnt_reg;
    logic [30:0] chk_hist_next;
    logic        chk_err;
    logic        chk_auto;
    logic        chk_run;
    logic        chk_locked;

    assign chk_auto   = chk_ctrl_reg[1];
    assign chk_run    = chk_ctrl_reg[0] && rx_valid;
    // manual mode counts at once; auto waits for its own hunt to settle
    assign chk_locked = chk_sync_reg || !chk_auto;

    always_comb begin
        chk_hist_next = chk_hist_reg;
        chk_err       = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if ((prbs_fb(chk_hist_next, chk_type_reg) ^ chk_inv_reg)
                != rx_data[i]) begin
                chk_err = 1'b1;
            end
            chk_hist_next = {chk_hist_next[29:0], rx_data[i]};
        end
    end

    // auto mode hunts through type and polarity until clean words follow
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            chk_hist_reg <= 31'h00000000;
            chk_type_reg <= 2'b00;
            chk_inv_reg  <= 1'b0;
            chk_sync_reg <= 1'b0;
            chk_good_reg <= 4'h0;
        end else if (!chk_auto) begin
            chk_type_reg <= chk_ctrl_reg[3:2];
            chk_inv_reg  <= chk_ctrl_reg[4];
            chk_sync_reg <= 1'b0;
            chk_good_reg <= 4'h0;
            if (chk_run) begin
                chk_hist_reg <= chk_hist_next;
            end
        end else if (chk_run) begin
            chk_hist_reg <= chk_hist_next;
            if (!chk_err) begin
                if (chk_good_reg == `SYNC_WORDS) begin
                    chk_sync_reg <= 1'b1;
                end else begin
                    chk_good_reg <= chk_good_reg + 4'h1;
                end
            end else if (!chk_sync_reg) begin
                {chk_type_reg, chk_inv_reg} <=
                    3'({chk_type_reg, chk_inv_reg} + 3'h1);
                chk_good_reg <= 4'h0;
            end
        end
    end

    // counters hold while frozen so the host reads a stable snapshot
    always_ff @(posedge sys_clk) begin
        if (!rstn || chk_ctrl_reg[6]) begin
            word_cnt_reg <= 47'h0;
            err_cnt_reg  <= 11'h000;
        end else if (chk_run && chk_locked && !chk_ctrl_reg[5]) begin
            word_cnt_reg <= word_cnt_reg + 47'h1;
            if (chk_err && err_cnt_reg != 11'h7ff) begin
                err_cnt_reg <= err_cnt_reg + 11'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // eye capture readout

    serdes_diag_pkg::eye_state_t eye_state_reg;
    logic [2:0] dummy_cnt_reg;
    logic       byte_sel_reg;
    logic       rd_high;
    logic       rd_low;
    logic       advance;
    logic       start_ok;

    assign rd_high = reg_rd && reg_addr == `WORD_HIGH_OFS
                     && !(reg_burst && byte_sel_reg);
    assign rd_low  = reg_rd && (reg_addr == `WORD_LOW_OFS
                     || (reg_addr == `WORD_HIGH_OFS && reg_burst
                         && byte_sel_reg));
    assign advance = rd_low && eye_state_reg != serdes_diag_pkg::EYE_IDLE;
    assign start_ok = start_req && locked_reg && eye_power_on
                      && !lock_mon_reg[`LOCK_MON_BIT];

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            byte_sel_reg <= 1'b0;
        end else if (reg_rd || reg_wr) begin
            byte_sel_reg <= rd_high && reg_burst;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            eye_state_reg <= serdes_diag_pkg::EYE_IDLE;
            dummy_cnt_reg <= 3'h0;
            eye_phase     <= 6'h00;
            eye_volt      <= 6'h00;
        end else begin
            case (eye_state_reg)
                serdes_diag_pkg::EYE_IDLE: begin
                    if (start_ok) begin
                        eye_state_reg <= serdes_diag_pkg::EYE_DUMMY;
                        dummy_cnt_reg <= 3'h0;
                        eye_phase     <= 6'h00;
                        eye_volt      <= 6'h00;
                    end
                end
                serdes_diag_pkg::EYE_DUMMY: begin
                    if (!locked_reg) begin
                        eye_state_reg <= serdes_diag_pkg::EYE_IDLE;
                    end else if (advance) begin
                        dummy_cnt_reg <= dummy_cnt_reg + 3'h1;
                        if (dummy_cnt_reg == `DUMMY_WORDS - 3'h1) begin
                            eye_state_reg <= serdes_diag_pkg::EYE_DATA;
                        end
                    end
                end
                serdes_diag_pkg::EYE_DATA: begin
                    if (!locked_reg) begin
                        eye_state_reg <= serdes_diag_pkg::EYE_IDLE;
                    end else if (advance) begin
                        eye_volt <= eye_volt + 6'h01;
                        if (eye_volt == `GRID_LAST) begin
                            eye_phase <= eye_phase + 6'h01;
                            if (eye_phase == `GRID_LAST) begin
                                eye_state_reg <= serdes_diag_pkg::EYE_IDLE;
                            end
                        end
                    end
                end
                default: eye_state_reg <= serdes_diag_pkg::EYE_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data

    logic [15:0] eye_word;
    logic        busy;

    assign busy     = eye_state_reg != serdes_diag_pkg::EYE_IDLE;
    assign eye_word = eye_state_reg == serdes_diag_pkg::EYE_DATA ? eye_hits
                                                                 : 16'h0000;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (rd_low) begin
                reg_rdata <= eye_word[7:0];
            end else begin
                case (reg_addr)
                    `RANGE_POWER_OFS:  reg_rdata <= range_power_reg;
                    `READOUT_CTRL_OFS: reg_rdata <= {fast_reg, 4'h0, busy,
                                                     aux_reg, 1'b0};
                    `WORD_HIGH_OFS:    reg_rdata <= eye_word[15:8];
                    `HORIZ_RESULT_OFS: reg_rdata <= horiz_reg;
                    `VERT_RESULT_OFS:  reg_rdata <= vert_reg;
                    `SCALING_CTRL_OFS: reg_rdata <= scaling_reg;
                    `LOCK_MON_OFS:     reg_rdata <= lock_mon_reg;
                    `GEN_CTRL_OFS:     reg_rdata <= gen_ctrl_reg;
                    `GEN_PAT_HI_OFS:   reg_rdata <= pattern_reg[15:8];
                    `GEN_PAT_LO_OFS:   reg_rdata <= pattern_reg[7:0];
                    `CHK_CTRL_OFS:     reg_rdata <= chk_ctrl_reg;
                    `CHK_STATUS_OFS:   reg_rdata <= {4'h0, chk_locked,
                                                     chk_inv_reg, chk_type_reg};
                    `ERR_CNT_LO_OFS:   reg_rdata <= err_cnt_reg[7:0];
                    `ERR_CNT_HI_OFS:   reg_rdata <= {5'h00, err_cnt_reg[10:8]};
                    default: begin
                        if (reg_addr >= `WORD_CNT0_OFS
                            && reg_addr < `ERR_CNT_LO_OFS) begin
                            reg_rdata <= 8'({1'b0, word_cnt_reg} >>
                                (8 * 3'(reg_addr - `WORD_CNT0_OFS)));
                        end else begin
                            reg_rdata <= 8'h00;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    a_start_self_clear: assert property
        (reg_rd && reg_addr == `READOUT_CTRL_OFS |=> !reg_rdata[0])
        else $error("start bit read back as one");

    a_start_needs_lock: assert property
        (eye_state_reg == serdes_diag_pkg::EYE_IDLE
        ##1 eye_state_reg == serdes_diag_pkg::EYE_DUMMY
        |-> $past(locked_reg, 1))
        else $error("capture started without lock");

    a_first_word_origin: assert property
        ($rose(eye_state_reg == serdes_diag_pkg::EYE_DATA)
        |-> eye_phase == 6'h00 && eye_volt == 6'h00
            && $past(dummy_cnt_reg) == 3'h3)
        else $error("data did not start at origin after four dummies");

    a_volt_wrap: assert property
        (advance && locked_reg && eye_state_reg == serdes_diag_pkg::EYE_DATA
        && eye_volt == 6'h3f && eye_phase != 6'h3f
        |=> eye_volt == 6'h00 && eye_phase == $past(eye_phase) + 6'h01)
        else $error("voltage wrap did not advance phase");

    a_volt_step: assert property
        (advance && locked_reg && eye_state_reg == serdes_diag_pkg::EYE_DATA
        && eye_volt != 6'h3f
        |=> eye_volt == $past(eye_volt) + 6'h01
            && $stable(eye_phase))
        else $error("voltage index did not step");

    a_high_holds_pos: assert property
        (rd_high && !start_ok |=> $stable(eye_volt) && $stable(eye_phase))
        else $error("high byte read moved the position");

    a_manual_range: assert property
        (!scaling_reg[`AUTO_SCALE_BIT]
        |=> eye_vrange == $past(range_power_reg[`RANGE_LSB +: 2]))
        else $error("manual range not applied");

    a_dc_balance: assert property
        (gen_ctrl_reg[2'h0] && !gen_ctrl_reg[1] && gen_ctrl_reg[4]
        ##1 $stable(gen_ctrl_reg) && $stable(pattern_reg)
        ##1 $stable(gen_ctrl_reg) && $stable(pattern_reg)
        |-> tx_data == ~$past(tx_data))
        else $error("balanced pattern did not alternate");

    a_user_pattern: assert property
        (gen_ctrl_reg[0] && !gen_ctrl_reg[1] && !gen_ctrl_reg[4]
        |=> tx_data == $past(pattern_reg))
        else $error("user pattern not sent");

    a_freeze_holds: assert property
        (chk_ctrl_reg[5] && !chk_ctrl_reg[6]
        |=> $stable(word_cnt_reg) && $stable(err_cnt_reg))
        else $error("counters moved while frozen");

    c_capture_done: cover property (@(posedge sys_clk) disable iff (!rstn)
        eye_state_reg == serdes_diag_pkg::EYE_DATA
        ##1 eye_state_reg == serdes_diag_pkg::EYE_IDLE);
    c_auto_sync: cover property (@(posedge sys_clk) disable iff (!rstn)
        chk_auto && $rose(chk_sync_reg));
    c_burst_low: cover property (@(posedge sys_clk) disable iff (!rstn)
        rd_low && reg_burst && advance);

endmodule

/* File: serdes_diag_cfg.svh */
`ifndef SERDES_DIAG_CFG_SVH
`define SERDES_DIAG_CFG_SVH

`define RANGE_POWER_OFS   8'h11
`define READOUT_CTRL_OFS  8'h24
`define WORD_HIGH_OFS     8'h25
`define WORD_LOW_OFS      8'h26
`define HORIZ_RESULT_OFS  8'h27
`define VERT_RESULT_OFS   8'h28
`define SCALING_CTRL_OFS  8'h2c
`define LOCK_MON_OFS      8'h67
`define GEN_CTRL_OFS      8'h30
`define GEN_PAT_HI_OFS    8'h31
`define GEN_PAT_LO_OFS    8'h32
`define CHK_CTRL_OFS      8'h33
`define CHK_STATUS_OFS    8'h34
`define WORD_CNT0_OFS     8'h35
`define ERR_CNT_LO_OFS    8'h3b
`define ERR_CNT_HI_OFS    8'h3c

`define RANGE_LSB         6
`define POWER_DOWN_BIT    5
`define FAST_BIT          7
`define AUX_BIT           1
`define BUSY_BIT          2
`define START_BIT         0
`define AUTO_SCALE_BIT    6
`define LOCK_MON_BIT      5

`define RANGE_POWER_RST   8'h20
`define SCALING_RST       8'h40
`define LOCK_MON_RST      8'h20
`define PRBS_SEED         31'h7fffffff

`define DUMMY_WORDS       3'h4
`define GRID_LAST         6'h3f
`define SYNC_WORDS        4'h8

`endif

/* File: serdes_diag_pkg.sv */
package serdes_diag_pkg;
    typedef enum logic [1:0] {
        EYE_IDLE  = 2'b00,
        EYE_DUMMY = 2'b01,
        EYE_DATA  = 2'b10
    } eye_state_t;

    typedef enum logic [1:0] {
        PRBS_7  = 2'b00,
        PRBS_9  = 2'b01,
        PRBS_15 = 2'b10,
        PRBS_31 = 2'b11
    } prbs_t;
endpackage

/* File: mgmt_host.sv */
`timescale 1ns/1ps
// host on the channel register port
module mgmt_host (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic            reg_burst,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_burst = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, input logic b,
                      output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_burst <= b;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

/* File: test_serdes_channel_diag_eye_monitor.sv */
`timescale 1ns/1ps
module test_serdes_channel_diag_eye_monitor;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cdr_locked = 1'b0;
    logic        rx_valid = 1'b0;
    logic [31:0] rx_data = 32'h0;
    logic [3:0]  rate = 4'h5;
    logic [7:0]  hm = 8'h5a;
    logic [7:0]  vm = 8'h33;
    logic [7:0]  addr, wdata, rdata, h, l;
    logic        wr, rd, burst, pwr, fast;
    logic [15:0] tx, a;
    logic [5:0]  ph, vo;
    logic [1:0]  vr;
    logic [3:0]  hs;
    int          err_count = 0;
    int          checked = 0;
    always #2 sys_clk = ~sys_clk;
    mgmt_host u_host (.sys_clk(sys_clk), .reg_rdata(rdata),
        .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_burst(burst),
        .reg_wdata(wdata));
    serdes_channel_diag_eye_monitor u_dut (.sys_clk(sys_clk), .rstn(rstn),
        .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_burst(burst),
        .reg_wdata(wdata), .reg_rdata(rdata), .tx_data(tx),
        .rx_data(rx_data), .rx_valid(rx_valid), .cdr_locked(cdr_locked),
        .data_rate_code(rate), .horiz_meas(hm), .vert_meas(vm),
        .eye_hits({ph, 4'ha, vo}), .eye_phase(ph), .eye_volt(vo),
        .eye_vrange(vr), .eye_hscale(hs), .eye_power_on(pwr),
        .eye_fast(fast));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic rchk(logic [7:0] ad, logic [7:0] e);
        u_host.rd(ad, 1'b0, h);
        chk("register", h, e);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk(8'h11, 8'h20);
        rchk(8'h2c, 8'h40);
        rchk(8'h67, 8'h20);
        rchk(8'h50, 8'h00);
        chk("power", pwr, 1'b0);
    endtask
    task automatic t_results();
        rchk(8'h27, 8'h5a);
        rchk(8'h28, 8'h33);
        chk("vrange auto", vr, 2'h0);
        chk("hscale", hs, 4'h5);
    endtask
    task automatic t_refuse();
        u_host.wr(8'h24, 8'h81);
        rchk(8'h24, 8'h80);
        u_host.wr(8'h24, 8'h00);
    endtask
    task automatic t_range();
        u_host.wr(8'h2c, 8'h00);
        for (int r = 0; r < 4; r++) begin
            u_host.wr(8'h11, {r[1:0], 6'h00});
            repeat (2) @(posedge sys_clk);
            chk("vrange", vr, r[1:0]);
            chk("power", pwr, 1'b1);
        end
    endtask
    task automatic t_capture();
        u_host.wr(8'h67, 8'h00);
        u_host.wr(8'h11, 8'hc0);
        u_host.wr(8'h24, 8'h80);
        u_host.wr(8'h24, 8'h81);
        rchk(8'h24, 8'h84);
        chk("fast", fast, 1'b1);
        for (int i = 0; i < 4; i++) begin
            u_host.rd(8'h25, 1'b0, h);
            u_host.rd(8'h26, 1'b0, l);
            chk("dummy", {h, l}, 16'h0000);
        end
        for (int i = 0; i < 4096; i++) begin
            a = {i[11:6], 4'ha, i[5:0]};
            u_host.rd(8'h25, i >= 64, h);
            if (i == 0) begin
                u_host.rd(8'h25, 1'b0, h);
                chk("high again", h, a[15:8]);
            end
            u_host.rd(i >= 64 ? 8'h25 : 8'h26, i >= 64, l);
            chk("eye word", {h, l}, a);
        end
        rchk(8'h24, 8'h80);
        u_host.wr(8'h67, 8'h20);
        u_host.wr(8'h2c, 8'h40);
        u_host.wr(8'h11, 8'h20);
        u_host.wr(8'h24, 8'h00);
    endtask
    task automatic t_gen();
        u_host.wr(8'h31, 8'ha5);
        u_host.wr(8'h32, 8'h3c);
        u_host.wr(8'h30, 8'h01);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("user pattern", tx, 16'ha53c);
        u_host.wr(8'h30, 8'h11);
        repeat (2) @(posedge sys_clk);
        #1;
        a = tx;
        @(posedge sys_clk);
        #1;
        chk("balance", tx ^ a, 16'hffff);
        u_host.wr(8'h30, 8'h03);
        repeat (2) @(posedge sys_clk);
        #1;
        a = tx;
        @(posedge sys_clk);
        #1;
        chk("prbs moves", tx != a, 1'b1);
    endtask
    task automatic t_count();
        u_host.wr(8'h33, 8'h41);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rx_valid <= 1'b0;
        u_host.wr(8'h33, 8'h21);
        rchk(8'h35, 8'h0a);
        rchk(8'h36, 8'h00);
        rchk(8'h3b, 8'h00);
        u_host.wr(8'h33, 8'h41);
        @(posedge sys_clk);
        rx_data <= 32'hffffffff;
        rx_valid <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rx_valid <= 1'b0;
        u_host.wr(8'h33, 8'h21);
        rchk(8'h35, 8'h03);
        rchk(8'h3b, 8'h03);
        u_host.wr(8'h33, 8'h43);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        repeat (12) @(posedge sys_clk);
        rx_valid <= 1'b0;
        u_host.rd(8'h34, 1'b0, h);
        chk("auto sync", h[3], 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        cdr_locked <= 1'b1;
        t_reset();
        repeat (6) @(posedge sys_clk);
        t_results();
        t_refuse();
        t_range();
        t_capture();
        t_gen();
        t_count();
        summarize();
    end
endmodule
